// >>> msad_pkg.sv
package msad_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 16;
    localparam int PC_W = 24;
    localparam int INSN_W = 24;
    localparam logic [23:0] RESET_PC = 24'h000000;
    localparam logic [23:0] RESET_TARGET_ADDR = 24'h000002;
    localparam logic [23:0] PRI_IVT_BASE = 24'h000004;
    localparam logic [23:0] ALT_IVT_BASE = 24'h000100;
    localparam logic [23:0] ALT_IVT_END = 24'h0001ff;
    localparam logic [23:0] USER_PROG_TOP = 24'h7fffff;
    localparam logic [23:0] PC_STEP = 24'h000002;
    localparam int TABLE_PAGE_SEL_BIT = 7;
    localparam logic [15:0] SFR_END = 16'h07ff;
    localparam logic [15:0] NEAR_END = 16'h1fff;
    localparam logic [15:0] RAM_END = 16'h77ff;
    localparam int RAM_WORDS = 64;
    localparam int RAM_IDX_W = 6;
    localparam int SFR_WORDS = 16;
    localparam int SFR_IDX_W = 4;
    localparam logic [15:0] RAM_BASE = 16'h0800;
    localparam logic [15:0] SFR_IMPL_END = 16'h001f;
    localparam logic [15:0] PTR_BYTE_STEP = 16'h0001;
    localparam logic [15:0] PTR_WORD_STEP = 16'h0002;
    typedef enum logic [1:0] {MSAD_EXT_NONE, MSAD_EXT_SIGN, MSAD_EXT_ZERO}
        msad_ext_t;
endpackage : msad_pkg

// >>> msad_decode.sv
`timescale 1ns/1ps
module msad_decode (
    input wire logic REF_CLK_I,
    input wire logic RESET_I,
    input wire logic PC_STEP_I,
    input wire logic PC_DOWN_I,
    input wire logic PC_LOAD_I,
    input wire logic [23:0] PC_LOAD_ADDR_I,
    input wire logic VECTOR_I,
    input wire logic VECTOR_ALT_I,
    input wire logic [6:0] VECTOR_NUM_I,
    output logic [23:0] PC_O,
    input wire logic [15:0] PROG_WORD_ADDR_I,
    input wire logic [15:0] PROG_WORD_DATA_I,
    output logic [15:0] PROG_WORD_DATA_O,
    input wire logic [23:0] TABLE_ADDR_I,
    input wire logic [7:0] TABLE_PAGE_I,
    output logic TABLE_ALLOWED_O,
    input wire logic RD_EN_I,
    input wire logic RD_BYTE_I,
    input wire logic RD_DIRECT_NEAR_I,
    input wire logic [12:0] RD_NEAR_ADDR_I,
    input wire logic [15:0] RD_ADDR_I,
    output logic [15:0] RD_DATA_O,
    output logic RD_PSV_O,
    output logic RD_SFR_O,
    input wire logic WR_EN_I,
    input wire logic WR_BYTE_I,
    input wire logic [15:0] WR_ADDR_I,
    input wire logic [15:0] WR_DATA_I,
    input wire logic PTR_INC_I,
    input wire logic PTR_BYTE_I,
    input wire logic [15:0] PTR_I,
    output logic [15:0] PTR_NEXT_O,
    input wire logic [3:0] WREG_SEL_I,
    input wire logic [1:0] EXT_OP_I,
    output logic ADDR_ERROR_TRAP_O,
    output logic WR_SUPPRESSED_O
);
    // ************************************************************
    // decode functions
    // ************************************************************
    function automatic logic in_psv(input logic [15:0] addr);
        in_psv = addr[15];
    endfunction : in_psv

    function automatic logic is_ram(input logic [15:0] addr);
        is_ram = !in_psv(addr) && (addr >= msad_pkg::RAM_BASE)
            && (addr < msad_pkg::RAM_BASE + 16'(2 * msad_pkg::RAM_WORDS))
            && (addr <= msad_pkg::RAM_END);
    endfunction : is_ram

    // only the first sixteen words of the special area are backed
    function automatic logic is_sfr(input logic [15:0] addr);
        is_sfr = (addr <= msad_pkg::SFR_IMPL_END);
    endfunction : is_sfr

    function automatic logic in_sfr_area(input logic [15:0] addr);
        in_sfr_area = (addr <= msad_pkg::SFR_END);
    endfunction : in_sfr_area

    function automatic logic [1:0] lane_strobe(input logic [15:0] addr,
        input logic byte_op);
        if (!byte_op)
            lane_strobe = 2'h3;
        else
            lane_strobe = addr[0] ? 2'h2 : 2'h1;
    endfunction : lane_strobe

    // ************************************************************
    // program counter
    // ************************************************************
    logic [23:0] pc_ff;
    logic [23:0] nxt_pc;
    logic [23:0] vec_base;
    logic [23:0] vec_target;
    // no range check: a large source number runs past the primary table into the alternate one
    assign vec_base = VECTOR_ALT_I ? msad_pkg::ALT_IVT_BASE
        : msad_pkg::PRI_IVT_BASE;
    assign vec_target = vec_base + {16'h0000, VECTOR_NUM_I, 1'b0};
    // vector wins over load, load over step
    always_comb
    begin
        nxt_pc = pc_ff;
        if (VECTOR_I)
            nxt_pc = vec_target;
        else if (PC_LOAD_I)
            nxt_pc = {PC_LOAD_ADDR_I[23:1], 1'b0};
        else if (PC_STEP_I)
            nxt_pc = PC_DOWN_I ? pc_ff - msad_pkg::PC_STEP
                : pc_ff + msad_pkg::PC_STEP;
    end
    always_ff @(posedge REF_CLK_I)
    begin
        if (RESET_I)
            pc_ff <= msad_pkg::RESET_PC;
        else
            pc_ff <= nxt_pc;
    end
    assign PC_O = pc_ff;

    // ************************************************************
    // program word layout and table access
    // ************************************************************
    // odd word holds upper instruction byte; its top byte is absent
    logic [15:0] prog_word_ff;
    always_ff @(posedge REF_CLK_I)
    begin
        if (RESET_I)
            prog_word_ff <= 16'h0000;
        else if (PROG_WORD_ADDR_I[0])
            prog_word_ff <= {8'h00, PROG_WORD_DATA_I[7:0]};
        else
            prog_word_ff <= PROG_WORD_DATA_I;
    end
    assign PROG_WORD_DATA_O = prog_word_ff;
    // upper half only through a table page with its top bit set
    assign TABLE_ALLOWED_O = (TABLE_ADDR_I <= msad_pkg::USER_PROG_TOP)
        || TABLE_PAGE_I[msad_pkg::TABLE_PAGE_SEL_BIT];

    // ************************************************************
    // write path, own address generator
    // ************************************************************
    logic wr_odd_word;
    logic wr_go;
    logic wr_in_sfr;
    logic wr_in_ram;
    logic [1:0] wr_lanes;
    logic [15:0] wr_ram_off;
    logic [15:0] wr_val;
    assign wr_odd_word = WR_EN_I && !WR_BYTE_I && WR_ADDR_I[0];
    assign wr_go = WR_EN_I && !wr_odd_word;
    // region decoded once here, not again in every storage word
    assign wr_in_sfr = wr_go && is_sfr(WR_ADDR_I);
    assign wr_in_ram = wr_go && is_ram(WR_ADDR_I);
    assign wr_lanes = lane_strobe(WR_ADDR_I, WR_BYTE_I);
    assign wr_ram_off = WR_ADDR_I - msad_pkg::RAM_BASE;
    // byte data arrives on the low lane and is steered to its side
    assign wr_val = WR_BYTE_I ? {WR_DATA_I[7:0], WR_DATA_I[7:0]}
        : WR_DATA_I;

    // ************************************************************
    // storage: special registers and data ram, two byte lanes
    // ************************************************************
    logic [15:0] sfr_ff [msad_pkg::SFR_WORDS];
    logic [15:0] ram_ff [msad_pkg::RAM_WORDS];

    // working registers share the sfr array; ext ops act on one of them
    logic [15:0] ext_src;
    assign ext_src = sfr_ff[WREG_SEL_I];

    genvar gi;
    generate
        for (gi = 0; gi < msad_pkg::SFR_WORDS; gi++)
        begin : g_sfr
            always_ff @(posedge REF_CLK_I)
            begin
                if (RESET_I)
                    sfr_ff[gi] <= 16'h0000;
                else if (EXT_OP_I == msad_pkg::MSAD_EXT_SIGN
                    && WREG_SEL_I == 4'(gi))
                    sfr_ff[gi] <= {{8{ext_src[7]}}, ext_src[7:0]};
                else if (EXT_OP_I == msad_pkg::MSAD_EXT_ZERO
                    && WREG_SEL_I == 4'(gi))
                    sfr_ff[gi] <= {8'h00, ext_src[7:0]};
                else if (wr_in_sfr && WR_ADDR_I[4:1] == 4'(gi))
                begin
                    if (wr_lanes[0])
                        sfr_ff[gi][7:0] <= wr_val[7:0];
                    if (wr_lanes[1])
                        sfr_ff[gi][15:8] <= wr_val[15:8];
                end
            end
        end
        for (gi = 0; gi < msad_pkg::RAM_WORDS; gi++)
        begin : g_ram
            always_ff @(posedge REF_CLK_I)
            begin
                if (RESET_I)
                    ram_ff[gi] <= 16'h0000;
                else if (wr_in_ram && wr_ram_off[6:1] == 6'(gi))
                begin
                    if (wr_lanes[0])
                        ram_ff[gi][7:0] <= wr_val[7:0];
                    if (wr_lanes[1])
                        ram_ff[gi][15:8] <= wr_val[15:8];
                end
            end
        end
    endgenerate

    // ************************************************************
    // read path, own address generator
    // ************************************************************
    logic [15:0] rd_addr;
    logic [15:0] rd_ram_off;
    logic [15:0] rd_word;
    logic [7:0] rd_byte;
    logic rd_odd_word;
    assign rd_addr = RD_DIRECT_NEAR_I ? {3'h0, RD_NEAR_ADDR_I}
        : RD_ADDR_I;
    assign rd_ram_off = rd_addr - msad_pkg::RAM_BASE;
    assign rd_odd_word = RD_EN_I && !RD_BYTE_I && rd_addr[0];
    // a word written in this same cycle is read back with its old value
    always_comb
    begin
        rd_word = 16'h0000;
        // visibility window lives outside this block; here it reads zero
        if (in_psv(rd_addr))
            rd_word = 16'h0000;
        else if (is_sfr(rd_addr))
            rd_word = sfr_ff[rd_addr[4:1]];
        else if (is_ram(rd_addr))
            rd_word = ram_ff[rd_ram_off[6:1]];
    end
    assign rd_byte = rd_addr[0] ? rd_word[15:8] : rd_word[7:0];

    logic [15:0] rd_data_ff;
    logic rd_psv_ff;
    logic rd_sfr_ff;
    always_ff @(posedge REF_CLK_I)
    begin
        if (RESET_I)
        begin
            rd_data_ff <= 16'h0000;
            rd_psv_ff <= 1'b0;
            rd_sfr_ff <= 1'b0;
        end
        else if (RD_EN_I)
        begin
            // misaligned read still completes, returning the aligned word
            if (RD_BYTE_I)
                rd_data_ff <= {8'h00, rd_byte};
            else
                rd_data_ff <= rd_word;
            rd_psv_ff <= in_psv(rd_addr);
            rd_sfr_ff <= in_sfr_area(rd_addr);
        end
    end
    assign RD_DATA_O = rd_data_ff;
    assign RD_PSV_O = rd_psv_ff;
    assign RD_SFR_O = rd_sfr_ff;

    // ************************************************************
    // pointer scaling and address error trap
    // ************************************************************
    // registered, so the core sees the stepped pointer a cycle later
    logic [15:0] ptr_ff;
    always_ff @(posedge REF_CLK_I)
    begin
        if (RESET_I)
            ptr_ff <= 16'h0000;
        else if (PTR_INC_I)
            ptr_ff <= PTR_I + (PTR_BYTE_I ? msad_pkg::PTR_BYTE_STEP
                : msad_pkg::PTR_WORD_STEP);
        else
            ptr_ff <= PTR_I;
    end
    assign PTR_NEXT_O = ptr_ff;

    // one-cycle pulse; the core takes the trap once the instruction ends
    logic trap_ff;
    logic wr_supp_ff;
    always_ff @(posedge REF_CLK_I)
    begin
        if (RESET_I)
        begin
            trap_ff <= 1'b0;
            wr_supp_ff <= 1'b0;
        end
        else
        begin
            trap_ff <= rd_odd_word || wr_odd_word;
            wr_supp_ff <= wr_odd_word;
        end
    end
    assign ADDR_ERROR_TRAP_O = trap_ff;
    assign WR_SUPPRESSED_O = wr_supp_ff;
endmodule : msad_decode

// >>> msad_checker.sv
`timescale 1ns/1ps
module msad_checker (
    input logic REF_CLK_I,
    input logic RESET_I,
    input logic PC_STEP_I,
    input logic PC_DOWN_I,
    input logic PC_LOAD_I,
    input logic VECTOR_I,
    input logic VECTOR_ALT_I,
    input logic [6:0] VECTOR_NUM_I,
    input logic [23:0] PC_O,
    input logic RD_EN_I,
    input logic RD_BYTE_I,
    input logic RD_DIRECT_NEAR_I,
    input logic [12:0] RD_NEAR_ADDR_I,
    input logic [15:0] RD_ADDR_I,
    input logic [15:0] RD_DATA_O,
    input logic RD_PSV_O,
    input logic WR_EN_I,
    input logic WR_BYTE_I,
    input logic [15:0] WR_ADDR_I,
    input logic ADDR_ERROR_TRAP_O,
    input logic WR_SUPPRESSED_O,
    input logic PTR_INC_I,
    input logic PTR_BYTE_I,
    input logic [15:0] PTR_I,
    input logic [15:0] PTR_NEXT_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (RESET_I);
    logic ra0;
    logic mis;
    // near reads carry their own low address bit
    assign ra0 = RD_DIRECT_NEAR_I ? RD_NEAR_ADDR_I[0] : RD_ADDR_I[0];
    assign mis = (RD_EN_I && !RD_BYTE_I && ra0)
        || (WR_EN_I && !WR_BYTE_I && WR_ADDR_I[0]);
    sequence s_odd_wr;
        WR_EN_I && !WR_BYTE_I && WR_ADDR_I[0];
    endsequence
    sequence s_wr_blocked;
        WR_SUPPRESSED_O && ADDR_ERROR_TRAP_O;
    endsequence
    a_pc_step_two: assert property (PC_STEP_I && !PC_LOAD_I
        && !VECTOR_I |=> PC_O == ($past(PC_DOWN_I)
        ? $past(PC_O) - 24'h000002 : $past(PC_O) + 24'h000002))
        else $error("pc step wrong");
    a_vec_base: assert property (VECTOR_I |=> PC_O
        == ($past(VECTOR_ALT_I) ? 24'h000100 : 24'h000004)
        + {$past(VECTOR_NUM_I), 1'b0}) else $error("vector address wrong");
    a_odd_rd_trap: assert property (RD_EN_I && !RD_BYTE_I && ra0
        |=> ADDR_ERROR_TRAP_O) else $error("no trap on odd read");
    a_odd_wr_stop: assert property (s_odd_wr |=> s_wr_blocked)
        else $error("odd write not suppressed");
    a_trap_cause: assert property (ADDR_ERROR_TRAP_O |-> $past(mis))
        else $error("trap without cause");
    a_byte_lane: assert property (RD_EN_I && RD_BYTE_I
        |=> RD_DATA_O[15:8] == 8'h00) else $error("byte high lane set");
    a_psv_bit: assert property (RD_EN_I && !RD_DIRECT_NEAR_I
        |=> RD_PSV_O == $past(RD_ADDR_I[15])) else $error("psv flag wrong");
    a_ptr_scale: assert property (PTR_INC_I |=> PTR_NEXT_O
        == $past(PTR_I) + ($past(PTR_BYTE_I) ? 16'h0001 : 16'h0002))
        else $error("pointer step wrong");
endmodule : msad_checker
bind msad_decode msad_checker u_msad_checker (.*);

// >>> msad_cpu_model.sv
`timescale 1ns/1ps
module msad_cpu_model (
    input logic REF_CLK_I,
    output logic RD_EN_I,
    output logic RD_BYTE_I,
    output logic RD_DIRECT_NEAR_I,
    output logic [12:0] RD_NEAR_ADDR_I,
    output logic [15:0] RD_ADDR_I,
    output logic WR_EN_I,
    output logic WR_BYTE_I,
    output logic [15:0] WR_ADDR_I,
    output logic [15:0] WR_DATA_I
);
    initial
    begin
        {RD_EN_I, RD_BYTE_I, RD_DIRECT_NEAR_I, RD_NEAR_ADDR_I} = '0;
        {RD_ADDR_I, WR_EN_I, WR_BYTE_I, WR_ADDR_I, WR_DATA_I} = '0;
    end
    // read and write paths own separate address sources
    task rd(input logic [15:0] a, input logic b, input logic n);
        @(posedge REF_CLK_I);
        #1;
        {RD_EN_I, RD_BYTE_I, RD_DIRECT_NEAR_I} = {1'b1, b, n};
        {RD_ADDR_I, RD_NEAR_ADDR_I} = {a, a[12:0]};
        @(posedge REF_CLK_I);
        #1;
        RD_EN_I = 1'b0;
        // idle address flips so a stale value never looks valid
        RD_ADDR_I = ~a;
    endtask : rd
    task wr(input logic [15:0] a, input logic [15:0] d, input logic b);
        @(posedge REF_CLK_I);
        #1;
        {WR_EN_I, WR_BYTE_I, WR_ADDR_I, WR_DATA_I} = {1'b1, b, a, d};
        @(posedge REF_CLK_I);
        #1;
        {WR_EN_I, WR_ADDR_I, WR_DATA_I} = {1'b0, ~a, ~d};
    endtask : wr
endmodule : msad_cpu_model

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic REF_CLK_I, RESET_I, PC_STEP_I, PC_DOWN_I, PC_LOAD_I, VECTOR_I;
    logic VECTOR_ALT_I, TABLE_ALLOWED_O, RD_EN_I, RD_BYTE_I, RD_DIRECT_NEAR_I;
    logic RD_PSV_O, RD_SFR_O, WR_EN_I, WR_BYTE_I, PTR_INC_I, PTR_BYTE_I;
    logic ADDR_ERROR_TRAP_O, WR_SUPPRESSED_O;
    logic [6:0] VECTOR_NUM_I;
    logic [7:0] TABLE_PAGE_I;
    logic [12:0] RD_NEAR_ADDR_I;
    logic [3:0] WREG_SEL_I;
    logic [1:0] EXT_OP_I;
    logic [15:0] PROG_WORD_ADDR_I, PROG_WORD_DATA_I, PROG_WORD_DATA_O;
    logic [15:0] RD_ADDR_I, RD_DATA_O, WR_ADDR_I, WR_DATA_I, PTR_I, PTR_NEXT_O;
    logic [23:0] PC_LOAD_ADDR_I, PC_O, TABLE_ADDR_I;
    int fails = 0;
    int compares = 0;
    msad_decode u_msad_decode (.*);
    msad_cpu_model u_msad_cpu_model (.*);
    initial
    begin
        REF_CLK_I = 1'b0;
        forever #2.5 REF_CLK_I = ~REF_CLK_I;
    end
    // ************
    // helpers
    // ************
    task cyc(input int n);
        repeat (n) @(posedge REF_CLK_I);
        #1;
    endtask : cyc
    task chk(input string n, input logic [23:0] e, input logic [23:0] g);
        compares++;
        if (g !== e)
        begin
            fails++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task test_done;
        $display("fails %0d compares %0d", fails, compares);
        if (fails == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    task ext(input logic [1:0] op);
        EXT_OP_I = op;
        cyc(1);
        EXT_OP_I = 2'h0;
    endtask : ext
    // ************
    // scenarios
    // ************
    task t_pc;
        chk("pc reset", 24'h000000, PC_O);
        PC_STEP_I = 1'b1;
        cyc(2);
        chk("pc up", 24'h000004, PC_O);
        PC_DOWN_I = 1'b1;
        cyc(1);
        chk("pc down", 24'h000002, PC_O);
        {PC_STEP_I, PC_DOWN_I, VECTOR_I, VECTOR_NUM_I} = {3'b001, 7'h03};
        cyc(1);
        chk("vec pri", 24'h00000a, PC_O);
        {VECTOR_ALT_I, VECTOR_NUM_I} = {1'b1, 7'h7f};
        cyc(1);
        chk("vec alt end", 24'h0001fe, PC_O);
        {VECTOR_I, PC_LOAD_I, PC_LOAD_ADDR_I} = {2'b01, 24'h000123};
        cyc(1);
        chk("pc load", 24'h000122, PC_O);
        PC_LOAD_I = 1'b0;
        $display("done t_pc");
    endtask : t_pc
    task t_mem;
        u_msad_cpu_model.wr(16'h0801, 16'h00ab, 1'b1);
        u_msad_cpu_model.wr(16'h0800, 16'h00cd, 1'b1);
        u_msad_cpu_model.rd(16'h0800, 1'b0, 1'b0);
        chk("word", 16'habcd, RD_DATA_O);
        u_msad_cpu_model.rd(16'h0801, 1'b1, 1'b0);
        chk("byte", 16'h00ab, RD_DATA_O);
        u_msad_cpu_model.wr(16'h0801, 16'hffff, 1'b0);
        chk("wr trap", 2'b11, {ADDR_ERROR_TRAP_O, WR_SUPPRESSED_O});
        u_msad_cpu_model.rd(16'h0801, 1'b0, 1'b0);
        chk("rd trap", 17'h1abcd, {ADDR_ERROR_TRAP_O, RD_DATA_O});
        u_msad_cpu_model.rd(16'h0800, 1'b0, 1'b1);
        chk("near", 16'habcd, RD_DATA_O);
        u_msad_cpu_model.rd(16'h0900, 1'b0, 1'b0);
        chk("unimpl", 16'h0000, RD_DATA_O);
        u_msad_cpu_model.rd(16'h0100, 1'b0, 1'b0);
        chk("sfr gap", 17'h10000, {RD_SFR_O, RD_DATA_O});
        u_msad_cpu_model.rd(16'hfffe, 1'b0, 1'b0);
        chk("psv", 3'b100, {RD_PSV_O, RD_SFR_O, RD_DATA_O[0]});
        $display("done t_mem");
    endtask : t_mem
    task t_reg;
        WREG_SEL_I = 4'h2;
        u_msad_cpu_model.wr(16'h0004, 16'h1280, 1'b0);
        u_msad_cpu_model.wr(16'h0004, 16'h0055, 1'b1);
        u_msad_cpu_model.rd(16'h0004, 1'b0, 1'b0);
        chk("byte load", 16'h1255, RD_DATA_O);
        u_msad_cpu_model.wr(16'h0004, 16'h0080, 1'b1);
        ext(2'h1);
        u_msad_cpu_model.rd(16'h0004, 1'b0, 1'b0);
        chk("sign ext", 16'hff80, RD_DATA_O);
        ext(2'h2);
        u_msad_cpu_model.rd(16'h0004, 1'b0, 1'b0);
        chk("zero ext", 16'h0080, RD_DATA_O);
        $display("done t_reg");
    endtask : t_reg
    task t_misc;
        {PTR_I, PTR_INC_I, PTR_BYTE_I} = {16'h0ffe, 2'b11};
        cyc(1);
        chk("ptr byte", 16'h0fff, PTR_NEXT_O);
        PTR_BYTE_I = 1'b0;
        cyc(1);
        chk("ptr word", 16'h1000, PTR_NEXT_O);
        PTR_INC_I = 1'b0;
        cyc(1);
        chk("ptr hold", 16'h0ffe, PTR_NEXT_O);
        {PROG_WORD_ADDR_I, PROG_WORD_DATA_I} = {16'h0003, 16'habcd};
        cyc(1);
        chk("top byte", 16'h00cd, PROG_WORD_DATA_O);
        PROG_WORD_ADDR_I = 16'h0002;
        cyc(1);
        chk("low word", 16'habcd, PROG_WORD_DATA_O);
        {TABLE_ADDR_I, TABLE_PAGE_I} = {24'h800000, 8'h7f};
        cyc(1);
        chk("tbl deny", 1'b0, TABLE_ALLOWED_O);
        TABLE_PAGE_I = 8'h80;
        #1;
        chk("tbl cfg", 1'b1, TABLE_ALLOWED_O);
        $display("done t_misc");
    endtask : t_misc
    initial
    begin
        {PC_STEP_I, PC_DOWN_I, PC_LOAD_I, VECTOR_I, VECTOR_ALT_I} = '0;
        {VECTOR_NUM_I, PC_LOAD_ADDR_I, PTR_INC_I, PTR_BYTE_I, PTR_I} = '0;
        {PROG_WORD_ADDR_I, PROG_WORD_DATA_I, TABLE_ADDR_I} = '0;
        {TABLE_PAGE_I, WREG_SEL_I, EXT_OP_I} = '0;
        RESET_I = 1'b1;
        cyc(16);
        RESET_I = 1'b0;
        t_pc;
        t_mem;
        t_reg;
        t_misc;
        test_done;
    end
    // run needs well under a microsecond; this cuts a hang
    initial
    begin
        #100000;
        fails++;
        test_done;
    end
endmodule : tb_top
